// *** rtl/eqs_encoder_emul.sv ***
`timescale 1ns/10ps
module eqs_encoder_emul
	import eqs_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic                          enc_a,
	input  wire logic                          enc_b,
	input  wire logic                          neg_sel,
	input  wire logic [eqs_pkg::LINES_W-1:0]   lines_per_rev,
	input  wire logic [eqs_pkg::SPEED_W-1:0]   speed,
	input  wire logic [eqs_pkg::MT_W-1:0]      pos_multi,
	input  wire logic [eqs_pkg::ST_W-1:0]      pos_single,
	input  wire logic                          ssi_clk,
	output logic      [eqs_pkg::POS_CNT_W-1:0] act_pos,
	output logic                               quad_out_chan_one,
	output logic                               quad_out_chan_two,
	output logic                               quad_out_ref,
	output logic                               ssi_data
);
	import eqs_pkg::*;

	logic [2:0] pins_s;
	logic       a_s;
	logic       b_s;
	logic       sclk_s;

	eqs_sync #(.W(3)) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({enc_a, enc_b, ssi_clk}),
		.q      (pins_s)
	);
	assign a_s    = pins_s[2];
	assign b_s    = pins_s[1];
	assign sclk_s = pins_s[0];

	// input decode: phase 0..3 walks 00,10,11,01 when track A leads
	logic [1:0] ph_prev_r;
	logic [1:0] ph_now;
	logic       fwd_raw;
	logic       bwd_raw;
	logic       cnt_up;
	logic       cnt_dn;
	assign ph_now  = {a_s & b_s | ~a_s & b_s, a_s ^ b_s};
	assign fwd_raw = ph_now == ph_prev_r + 2'h1;
	assign bwd_raw = ph_prev_r == ph_now + 2'h1;
	assign cnt_up  = neg_sel ? bwd_raw : fwd_raw;
	assign cnt_dn  = neg_sel ? fwd_raw : bwd_raw;

	// actual position counter; an illegal double step is ignored
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ph_prev_r <= 2'h0;
			act_pos   <= '0;
		end
		else
		begin
			ph_prev_r <= ph_now;
			if (cnt_up)
				act_pos <= act_pos + 32'h1;
			else if (cnt_dn)
				act_pos <= act_pos - 32'h1;
		end
	end

	// emulation rate: 4 edges per line, lines x rev/s per second
	logic [SPEED_W-1:0] spd_mag;
	logic               spd_fwd;
	logic [ACC_W-1:0]   edge_inc;
	logic [ACC_W-1:0]   acc_r;
	logic [ACC_W-1:0]   acc_sum;
	logic               emu_step;
	logic [17:0]        step_r;
	logic [17:0]        step_top;
	logic [17:0]        step_nxt;
	assign spd_fwd  = ~speed[SPEED_W-1];
	assign spd_mag  = spd_fwd ? speed : SPEED_W'(-speed);
	assign edge_inc = ACC_W'({lines_per_rev, 2'b00}) * ACC_W'(spd_mag);
	assign acc_sum  = acc_r + edge_inc;
	assign emu_step = acc_sum >= ACC_WRAP;
	assign step_top = {lines_per_rev, 2'b00} - 18'h1;
	// count steps modulo one revolution so the mark lands once per turn
	assign step_nxt = (!emu_step || lines_per_rev == '0) ? step_r :
			spd_fwd ? ((step_r >= step_top) ? 18'h0 : step_r + 18'h1) :
			((step_r == 18'h0) ? step_top : step_r - 18'h1);

	// outputs come straight from flops; up to 100 MHz edge rate, far above need
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc_r             <= '0;
			step_r            <= '0;
			quad_out_chan_one <= 1'b0;
			quad_out_chan_two <= 1'b0;
			quad_out_ref      <= 1'b0;
		end
		else
		begin
			acc_r             <= emu_step ? acc_sum - ACC_WRAP : acc_sum;
			step_r            <= step_nxt;
			quad_out_chan_one <= step_nxt[1] ^ step_nxt[0];
			quad_out_chan_two <= step_nxt[1];
			quad_out_ref      <= step_nxt == 18'h2;
		end
	end

	// absolute word: multi-turn above single-turn, then Gray coded
	logic [POS_W-1:0] bin_w;
	logic [POS_W-1:0] gray_w;
	assign bin_w  = {pos_multi, pos_single};
	assign gray_w = bin_w ^ (bin_w >> 1);

	// serial frame; clock idles high, falling edge opens a frame
	logic                  sclk_d_r;
	logic                  rise_w;
	logic                  fall_w;
	eqs_frame_t            st_r;
	logic [FRAME_BITS-1:0] hold_r;
	logic [4:0]            bit_r;
	logic [11:0]           idle_r;
	logic                  tmo_w;
	assign rise_w = sclk_s & ~sclk_d_r;
	assign fall_w = ~sclk_s & sclk_d_r;
	assign tmo_w  = idle_r == 12'(TP_CYC - 1);

	// idle timer: the controller break ends the frame, not a bit count
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			idle_r <= '0;
		else if (!sclk_s || rise_w || fall_w)
			idle_r <= '0;
		else if (!tmo_w)
			idle_r <= idle_r + 12'h1;
	end

	// frame engine; data shifts on rising edges, MSB first
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_d_r <= 1'b0; // same as the synchroniser reset, so release shows no false fall
			st_r     <= EQS_IDLE;
			hold_r   <= '0;
			bit_r    <= '0;
			ssi_data <= 1'b1;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			unique case (st_r)
				EQS_IDLE:
				begin
					ssi_data <= 1'b1;
					if (fall_w)
					begin
						hold_r <= {gray_w, PWR_FAIL_VAL};
						bit_r  <= '0;
						st_r   <= EQS_SHIFT;
					end
				end
				EQS_SHIFT:
				begin
					if (tmo_w)
					begin
						st_r     <= EQS_IDLE;
						ssi_data <= 1'b1;
					end
					else if (rise_w)
					begin
						// hold register shifts; zero fill past the last bit
						ssi_data <= hold_r[FRAME_BITS-1];
						hold_r   <= {hold_r[FRAME_BITS-2:0], 1'b0};
						if (bit_r != 5'h1F)
							bit_r <= bit_r + 5'h1;
					end
				end
			endcase
		end
	end

	// bit edge one cycle early: the data register follows it
	localparam int TV_LIM = TV_CYC - 1;

	sequence seq_frame_open;
		st_r == EQS_IDLE && fall_w;
	endsequence

	sequence seq_bit_edge;
		st_r == EQS_SHIFT && rise_w && !tmo_w;
	endsequence

	AST_QUAD_LEAD: assert property (@(posedge clk) disable iff (!arst_n)
		(emu_step && spd_fwd && lines_per_rev != '0 && step_r[1:0] == 2'h0)
		|=> (quad_out_chan_one && !quad_out_chan_two))
		else $error("channel one did not lead channel two");

	AST_COUNT_UP: assert property (@(posedge clk) disable iff (!arst_n)
		(fwd_raw && !neg_sel) |=> act_pos == $past(act_pos) + 32'h1)
		else $error("position did not count up with track A leading");

	AST_REF_QUAD: assert property (@(posedge clk) disable iff (!arst_n)
		quad_out_ref |-> (quad_out_chan_one && quad_out_chan_two))
		else $error("reference mark outside zeroth quadrant");

	AST_RATE_STILL: assert property (@(posedge clk) disable iff (!arst_n)
		(speed == '0 && acc_r < ACC_WRAP) [*2] |=> $stable(quad_out_chan_one))
		else $error("tracks moved at zero speed");

	AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
		(seq_bit_edge and (bit_r == 5'h0)) |=> ssi_data == $past(hold_r[FRAME_BITS-1]))
		else $error("first serial bit is not the Gray MSB");

	AST_MULTI_TOP: assert property (@(posedge clk) disable iff (!arst_n)
		seq_frame_open |=> hold_r[FRAME_BITS-1 -: MT_W]
			== ($past(pos_multi) ^ ($past(pos_multi) >> 1)))
		else $error("multi-turn count not in upper part of word");

	AST_PFB_LOW: assert property (@(posedge clk) disable iff (!arst_n)
		(seq_bit_edge and (bit_r == 5'(POS_W))) |=> !ssi_data)
		else $error("power fail flag bit sent high");

	AST_TV_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
		(st_r == EQS_SHIFT && !tmo_w && $rose(ssi_clk)) |-> ##[1:TV_LIM] seq_bit_edge)
		else $error("serial bit late after clock edge");

	AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		seq_frame_open ##1 (!rise_w && !tmo_w && st_r == EQS_SHIFT) |=> $stable(hold_r))
		else $error("held position changed during frame");
endmodule

// *** rtl/eqs_pkg.sv ***
package eqs_pkg;
	localparam int          CLK_HZ     = 100_000_000;
	localparam int          CLK_MHZ    = 100;
	// serial frame layout
	localparam int          MT_W       = 12;
	localparam int          ST_W       = 12;
	localparam int          POS_W      = MT_W + ST_W;
	localparam int          FRAME_BITS = POS_W + 1;
	localparam logic        PWR_FAIL_VAL = 1'b0;
	// serial timing
	localparam int          TV_MAX_NS  = 200;
	localparam int          TV_CYC     = TV_MAX_NS * CLK_MHZ / 1000;
	localparam int          TP_MIN_NS  = 20_000;
	localparam int          TP_CYC     = TP_MIN_NS * CLK_MHZ / 1000;
	// emulation
	localparam int          LINES_W    = 16;
	localparam int          SPEED_W    = 16;
	localparam int          ACC_W      = 40;
	localparam logic [39:0] ACC_WRAP   = 40'(CLK_HZ);
	localparam int          POS_CNT_W  = 32;
	typedef enum logic { EQS_IDLE = 1'b0, EQS_SHIFT = 1'b1 } eqs_frame_t;
endpackage

// *** rtl/eqs_sync.sv ***
`timescale 1ns/10ps
// two-flop synchroniser; only the second stage leaves this module
module eqs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** tb/eqs_ctrl_model.sv ***
`timescale 1ns/10ps
// far-end controller: counts track edges, clocks the serial position link
module eqs_ctrl_model
	import eqs_pkg::*;
(
	input  wire logic quad_out_chan_one,
	input  wire logic quad_out_chan_two,
	input  wire logic ssi_data,
	output logic      ssi_clk
);
	int         edges   = 0;
	logic [1:0] ph_prev = 2'h0;
	logic [1:0] ph_now;
	// link clock idles high and stands still between frames
	initial ssi_clk = 1'b1;
	// ideal sampling, wider than any filter bandwidth; speed from edge count only
	always @(quad_out_chan_one or quad_out_chan_two)
	begin
		ph_now = {quad_out_chan_two, quad_out_chan_one ^ quad_out_chan_two};
		if (2'(ph_now - ph_prev) == 2'h1)
			edges++;
		else if (2'(ph_prev - ph_now) == 2'h1)
			edges--;
		ph_prev = ph_now;
	end
	// one frame at 8 MHz, sampled a half period after each rise, then the break
	task automatic read_frame(output logic [FRAME_BITS-1:0] w);
		ssi_clk = 1'b0;
		for (int i = FRAME_BITS - 1; i >= 0; i--)
		begin
			#62.5 ssi_clk = 1'b1;
			#62.5 w[i] = ssi_data;
			if (i > 0)
				ssi_clk = 1'b0;
		end
		#20100;
	endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
	import eqs_pkg::*;
	typedef struct {logic [11:0] mt; logic [11:0] st; logic [23:0] g;} eqs_row_t;
	logic        clk, arst_n, enc_a, enc_b, neg_sel, ssi_clk, q1, q2, qref, sdat;
	logic [15:0] lines, spd;
	logic [11:0] pmt, pst;
	logic [31:0] act_pos;
	logic [24:0] w;
	int          failures = 0, check_count = 0, refs = 0, e0, d;
	// position inputs beside the expected Gray word
	eqs_row_t    rows[5] = '{'{12'h000, 12'h001, 24'h000001}, '{12'hFFF, 12'hFFF, 24'h800000},
		'{12'h800, 12'h000, 24'hC00000}, '{12'h001, 12'h000, 24'h001800},
		'{12'h555, 12'h555, 24'h7FFFFF}};
	eqs_encoder_emul u_dut (.clk(clk), .arst_n(arst_n), .enc_a(enc_a), .enc_b(enc_b),
		.neg_sel(neg_sel), .lines_per_rev(lines), .speed(spd), .pos_multi(pmt),
		.pos_single(pst), .ssi_clk(ssi_clk), .act_pos(act_pos), .quad_out_chan_one(q1),
		.quad_out_chan_two(q2), .quad_out_ref(qref), .ssi_data(sdat));
	eqs_ctrl_model u_ctrl (.quad_out_chan_one(q1), .quad_out_chan_two(q2),
		.ssi_data(sdat), .ssi_clk(ssi_clk));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// pins held well past the three-cycle minimum
	task automatic enc(logic a, logic b);
		@(negedge clk);
		enc_a = a;
		enc_b = b;
		repeat (5) @(negedge clk);
	endtask
	// mark may only sit where both tracks are high
	always @(negedge clk)
	begin
		if (arst_n === 1'b1 && qref === 1'b1)
		begin
			refs++;
			chk("ref_quadrant", 32'h1, 32'(q1 & q2));
		end
	end
	// a hang costs a mismatch and ends the run
	initial
	begin
		#1ms;
		failures++;
		tally_and_finish();
	end
	initial
	begin
		{arst_n, enc_a, enc_b, neg_sel, lines, spd, pmt, pst} = '0;
		repeat (8) @(negedge clk);
		chk("reset_pos", 32'h0, act_pos);
		chk("reset_quad", 32'h0, {q1, q2, qref});
		chk("reset_sdat", 32'h1, sdat);
		arst_n = 1'b1;
		// link clock stays high while the synchroniser fills
		repeat (2) @(negedge clk);
		foreach (rows[i])
		begin
			@(negedge clk);
			pmt = rows[i].mt;
			pst = rows[i].st;
			u_ctrl.read_frame(w);
			chk("frame", {rows[i].g, PWR_FAIL_VAL}, w);
			chk("idle_sdat", 32'h1, sdat);
		end
		// value changes mid-frame must not reach the word
		@(negedge clk);
		pmt = 12'h000;
		pst = 12'h001;
		fork
			u_ctrl.read_frame(w);
			#1000 pst = 12'h002;
		join
		chk("held_frame", 32'h2, w);
		enc(1, 0);
		enc(1, 1);
		enc(0, 1);
		enc(0, 0);
		chk("pos_up", 32'h4, act_pos);
		neg_sel = 1'b1;
		enc(1, 0);
		enc(1, 1);
		chk("pos_neg", 32'h2, act_pos);
		enc(0, 0);
		chk("pos_jump", 32'h2, act_pos);
		enc(0, 1);
		chk("pos_neg_back", 32'h3, act_pos);
		// track B leading without negation counts down
		neg_sel = 1'b0;
		enc(0, 0);
		enc(0, 1);
		chk("pos_down", 32'h3, act_pos);
		enc(0, 0);
		// 500 lines at 5000 rev/s: 200 edges in 2000 cycles, sign from direction
		lines = 16'h01F4;
		spd = 16'h1388;
		e0 = u_ctrl.edges;
		repeat (2000) @(negedge clk);
		d = u_ctrl.edges - e0;
		chk("fwd_edges", 32'h1, 32'(d >= 198 && d <= 201));
		spd = 16'hEC78;
		e0 = u_ctrl.edges;
		repeat (2000) @(negedge clk);
		d = u_ctrl.edges - e0;
		chk("rev_edges", 32'h1, 32'(d <= -198 && d >= -201));
		chk("ref_seen", 32'h1, 32'(refs > 0));
		lines = 16'h0000;
		repeat (20) @(negedge clk);
		e0 = u_ctrl.edges;
		repeat (200) @(negedge clk);
		chk("frozen", 32'(e0), 32'(u_ctrl.edges));
		// reset in mid-run: state clears, idle-high link clock opens no frame
		arst_n = 1'b0;
		@(negedge clk);
		chk("mid_reset_pos", 32'h0, act_pos);
		chk("mid_reset_quad", 32'h0, {q1, q2, qref});
		arst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("release_sdat", 32'h1, sdat);
		chk("release_pos", 32'h0, act_pos);
		pmt = rows[1].mt;
		pst = rows[1].st;
		u_ctrl.read_frame(w);
		chk("frame_after_reset", {rows[1].g, PWR_FAIL_VAL}, w);
		tally_and_finish();
	end
endmodule
